// ==== common/adc_ctl_pkg.sv ====
// Register map, field positions and shared types for the converter control.
// Assumes an 8-bit register file behind a 32-bit classic Wishbone slave.
package adc_ctl_pkg;

  // Printed offsets are register indices; byte address is index times four
  localparam logic [4:0] IDX_CONTROL_A  = 5'h00;
  localparam logic [4:0] IDX_CONTROL_B  = 5'h01;
  localparam logic [4:0] IDX_CONTROL_C  = 5'h02;
  localparam logic [4:0] IDX_CONTROL_D  = 5'h03;
  localparam logic [4:0] IDX_WINDOW     = 5'h04;
  localparam logic [4:0] IDX_SAMPLEN    = 5'h05;
  localparam logic [4:0] IDX_POSITIVE_INPUT_SELECT     = 5'h06;
  localparam logic [4:0] IDX_COMMAND    = 5'h08;
  localparam logic [4:0] IDX_EVENT_INPUT_CONTROL     = 5'h09;
  localparam logic [4:0] IDX_INT_ENABLE = 5'h0A;
  localparam logic [4:0] IDX_INT_PEND   = 5'h0B;
  localparam logic [4:0] IDX_DEBUG      = 5'h0C;
  localparam logic [4:0] IDX_SCRATCH    = 5'h0D;
  localparam logic [4:0] IDX_RESULT_LO  = 5'h10;
  localparam logic [4:0] IDX_RESULT_HI  = 5'h11;
  localparam logic [4:0] IDX_WINDOW_LOW_THRESHOLD_LO   = 5'h12;
  localparam logic [4:0] IDX_WINDOW_LOW_THRESHOLD_HI   = 5'h13;
  localparam logic [4:0] IDX_WINDOW_HIGH_THRESHOLD_LO   = 5'h14;
  localparam logic [4:0] IDX_WINDOW_HIGH_THRESHOLD_HI   = 5'h15;
  localparam logic [4:0] IDX_DUTY_CYCLE_TUNING      = 5'h16;

  // Control A bit positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_CONTINUOUS_CONVERSION  = 1;
  localparam int BIT_RESOLUTION_SELECT   = 2;
  localparam int BIT_STANDBY  = 7;
  // Control C bit positions
  localparam int BIT_SAMPLE_CAP_SELECT  = 6;
  localparam int POS_REFERENCE_SELECT   = 4;
  // Flag bit positions
  localparam int BIT_RESULT_READY_FLAG   = 0;
  localparam int BIT_WINDOW_COMPARE_FLAG    = 1;

  // Writable masks per register, reserved bits read zero
  localparam logic [7:0] MASK_CONTROL_A = 8'h87;
  localparam logic [7:0] MASK_CONTROL_B = 8'h07;
  localparam logic [7:0] MASK_CONTROL_C = 8'h77;
  localparam logic [7:0] MASK_WINDOW    = 8'h07;
  localparam logic [7:0] MASK_SAMPLEN   = 8'h1F;
  localparam logic [7:0] MASK_BIT0      = 8'h01;
  localparam logic [7:0] MASK_FLAGS     = 8'h03;

  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [2:0]  ACC_RESERVED  = 3'h7;
  localparam logic [7:0]  DIV_ZERO      = 8'h00;
  localparam logic [4:0]  CYC_BASE      = 5'h0E; // Cycles per sample, base

  // Window comparator modes
  typedef enum logic [2:0] {
    WIN_NONE    = 3'h0,
    WIN_BELOW   = 3'h1,
    WIN_ABOVE   = 3'h2,
    WIN_INSIDE  = 3'h3,
    WIN_OUTSIDE = 3'h4
  } win_mode_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_DONE   = 2'b10
  } conv_state_t;

  // Analog core control bundle
  typedef struct packed {
    logic       sample_go;
    logic       sample_cap_select;
    logic [1:0] reference_select;
    logic       converter_on;
  } analog_ctl_t;

endpackage : adc_ctl_pkg

// ==== src/adc_control_registers.sv ====
// Register file and conversion sequencer of a successive-approximation ADC.
// Assumes a 10-bit analog core on I_REF_CLK answering each sample request.
//
// Overview of operation
// - With resolution select clear, full 10-bit samples are accumulated or stored.
// - With resolution select set, the two lowest sample bits are dropped.
// - Continuous mode restarts right after completion; each completion sets ready.
// - Converter runs only while control A bit zero is one.
// - Run-in-standby bit decides whether the converter runs during standby.
// - Accumulation code picks 1,2,4..64 samples; code seven is reserved.
// - Nonzero accumulation sums the samples into one result.
// - Sample capacitance bit selects the reduced capacitor when set.
// - Reference field chooses internal at zero, supply at one.
// - Prescaler divides the peripheral clock by two up to 256.
// - Start bit reads one while busy, clears on completion outside continuous mode; zero aborts.
// - With event start enabled, an event rising edge starts a conversion.
// - Interrupt is high while a flag and its enable are both set.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module adc_control_registers (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESET,
  input  wire logic        I_CLK_EN,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [6:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_STANDBY,
  input  wire logic        I_START_EVENT,
  input  wire logic [9:0]  I_SAMPLE_DATA,
  input  wire logic        I_SAMPLE_VALID,
  output logic             O_CONVERTER_ON,
  output logic             O_SAMPLE_GO,
  output logic             O_SAMPLE_CAP_SELECT,
  output logic      [1:0]  O_REFERENCE_SELECT,
  output logic      [4:0]  O_INPUT_SELECT,
  output logic             O_CONV_CLK_EN,
  output logic             O_IRQ
);

  // Register storage
  logic [7:0]  ctla_q, ctlb_q, ctlc_q, ctld_q, wine_q, samp_q, mux_q;
  logic [7:0]  evc_q, ien_q, flg_q, dbg_q, tmp_q, cal_q;
  logic [15:0] res_q, window_low_threshold_q, window_high_threshold_q, acc_q;
  logic [6:0]  cnt_q;
  logic [7:0]  div_q;
  logic        ack_q, irq_q, go_q, cke_q;
  logic [31:0] rdat_q;
  logic [2:0]  evt_sync_q;
  adc_ctl_pkg::conv_state_t   st_q;
  adc_ctl_pkg::analog_ctl_t   ana_q;

  // Sample count from accumulation code
  function automatic logic [6:0] acc_total(input logic [2:0] code);
    logic [6:0] n;
    n = 7'h01 << code;
    if (code == adc_ctl_pkg::ACC_RESERVED) begin
      n = 7'h01; // Reserved code behaves as no accumulation
    end
    return n;
  endfunction : acc_total

  // Window comparison for the selected mode
  function automatic logic win_hit(input logic [2:0] m, input logic [15:0] r,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    logic h;
    h = 1'b0;
    case (m)
      adc_ctl_pkg::WIN_BELOW:   h = r < lo;
      adc_ctl_pkg::WIN_ABOVE:   h = r > hi;
      adc_ctl_pkg::WIN_INSIDE:  h = (r > lo) && (r < hi);
      adc_ctl_pkg::WIN_OUTSIDE: h = (r < lo) || (r > hi);
      default:                  h = 1'b0;
    endcase
    return h;
  endfunction : win_hit

  // Bus decode; a single-cycle request acked once
  wire         req      = I_WB_CYC && I_WB_STB && !ack_q;
  wire         wr       = req && I_WB_WE && I_WB_SEL[0];
  wire  [4:0]  idx      = I_WB_ADR[6:2];
  wire  [7:0]  wd       = I_WB_DAT[7:0];
  // Index uses all five upper address bits, so results at 0x10 up are reached
  wire         wr_cmd   = wr && idx == adc_ctl_pkg::IDX_COMMAND;
  wire         wr_flg   = wr && idx == adc_ctl_pkg::IDX_INT_PEND;

  // Enable and standby gating
  wire         enabled  = ctla_q[adc_ctl_pkg::BIT_ENABLE];
  wire         running  = enabled &&
                 (!I_STANDBY || ctla_q[adc_ctl_pkg::BIT_STANDBY]);
  wire         continuous_conversion  = ctla_q[adc_ctl_pkg::BIT_CONTINUOUS_CONVERSION];
  wire         busy     = st_q != adc_ctl_pkg::ST_IDLE;

  // Start sources: software write or event rising edge
  wire         evt_edge = evt_sync_q[1] && !evt_sync_q[2];
  wire         evt_go   = evt_edge && evc_q[0];
  wire         sw_go    = wr_cmd && wd[0];
  wire         abort    = wr_cmd && !wd[0] && busy;
  wire         start    = running && !busy && (sw_go || evt_go);

  // Sample shaping by resolution
  wire  [9:0]  shaped   = ctla_q[adc_ctl_pkg::BIT_RESOLUTION_SELECT] ?
                 {2'b00, I_SAMPLE_DATA[9:2]} :
                 I_SAMPLE_DATA;
  wire  [15:0] acc_next = acc_q + {6'h00, shaped};
  wire  [6:0]  total    = acc_total(ctlb_q[2:0]);
  wire         take     = st_q == adc_ctl_pkg::ST_SAMPLE && I_SAMPLE_VALID;
  wire         last     = take && (cnt_q + 7'h01 == total);
  wire         done     = st_q == adc_ctl_pkg::ST_DONE;
  wire         hit      = win_hit(wine_q[2:0], acc_q, window_low_threshold_q, window_high_threshold_q);

  // Prescaler compare: counter reaches terminal count (2 << control C bits 2:0) - 1
  wire  [7:0]  div_max  = 8'((16'h0002 << ctlc_q[2:0]) - 16'h0001);
  wire         div_tick = div_q == div_max;

  // Read mux; unmapped indices read zero
  logic [7:0] rsel;
  always_comb begin
    rsel = adc_ctl_pkg::RESET_BYTE;
    begin
      case (idx)
        adc_ctl_pkg::IDX_CONTROL_A:  rsel = ctla_q;
        adc_ctl_pkg::IDX_CONTROL_B:  rsel = ctlb_q;
        adc_ctl_pkg::IDX_CONTROL_C:  rsel = ctlc_q;
        adc_ctl_pkg::IDX_CONTROL_D:  rsel = ctld_q;
        adc_ctl_pkg::IDX_WINDOW:     rsel = wine_q;
        adc_ctl_pkg::IDX_SAMPLEN:    rsel = samp_q;
        adc_ctl_pkg::IDX_POSITIVE_INPUT_SELECT:     rsel = mux_q;
        adc_ctl_pkg::IDX_COMMAND:    rsel = {7'h00, busy};
        adc_ctl_pkg::IDX_EVENT_INPUT_CONTROL:     rsel = evc_q;
        adc_ctl_pkg::IDX_INT_ENABLE: rsel = ien_q;
        adc_ctl_pkg::IDX_INT_PEND:   rsel = flg_q;
        adc_ctl_pkg::IDX_DEBUG:      rsel = dbg_q;
        adc_ctl_pkg::IDX_SCRATCH:    rsel = tmp_q;
        adc_ctl_pkg::IDX_RESULT_LO:  rsel = res_q[7:0];
        adc_ctl_pkg::IDX_RESULT_HI:  rsel = res_q[15:8];
        adc_ctl_pkg::IDX_WINDOW_LOW_THRESHOLD_LO:   rsel = window_low_threshold_q[7:0];
        adc_ctl_pkg::IDX_WINDOW_LOW_THRESHOLD_HI:   rsel = window_low_threshold_q[15:8];
        adc_ctl_pkg::IDX_WINDOW_HIGH_THRESHOLD_LO:   rsel = window_high_threshold_q[7:0];
        adc_ctl_pkg::IDX_WINDOW_HIGH_THRESHOLD_HI:   rsel = window_high_threshold_q[15:8];
        adc_ctl_pkg::IDX_DUTY_CYCLE_TUNING:      rsel = cal_q;
        default:                     rsel = adc_ctl_pkg::RESET_BYTE;
      endcase
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (I_CLK_EN) begin
      ack_q  <= req;
      rdat_q <= req ? {24'h00_0000, rsel} : 32'h0000_0000;
    end
  end

  // Configuration writes, masked so reserved bits stay zero
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      {ctla_q, ctlb_q, ctlc_q, ctld_q} <= {4{adc_ctl_pkg::RESET_BYTE}};
      {wine_q, samp_q, mux_q, evc_q}   <= {4{adc_ctl_pkg::RESET_BYTE}};
      {ien_q, dbg_q, tmp_q, cal_q}     <= {4{adc_ctl_pkg::RESET_BYTE}};
      window_low_threshold_q <= adc_ctl_pkg::RESET_WORD;
      window_high_threshold_q <= adc_ctl_pkg::RESET_WORD;
    end else if (I_CLK_EN && wr) begin
      case (idx)
        adc_ctl_pkg::IDX_CONTROL_A:  ctla_q <= wd & adc_ctl_pkg::MASK_CONTROL_A;
        adc_ctl_pkg::IDX_CONTROL_B:  ctlb_q <= wd & adc_ctl_pkg::MASK_CONTROL_B;
        adc_ctl_pkg::IDX_CONTROL_C:  ctlc_q <= wd & adc_ctl_pkg::MASK_CONTROL_C;
        adc_ctl_pkg::IDX_CONTROL_D:  ctld_q <= wd;
        adc_ctl_pkg::IDX_WINDOW:     wine_q <= wd & adc_ctl_pkg::MASK_WINDOW;
        adc_ctl_pkg::IDX_SAMPLEN:    samp_q <= wd & adc_ctl_pkg::MASK_SAMPLEN;
        adc_ctl_pkg::IDX_POSITIVE_INPUT_SELECT:     mux_q  <= wd & adc_ctl_pkg::MASK_SAMPLEN;
        adc_ctl_pkg::IDX_EVENT_INPUT_CONTROL:     evc_q  <= wd & adc_ctl_pkg::MASK_BIT0;
        adc_ctl_pkg::IDX_INT_ENABLE: ien_q  <= wd & adc_ctl_pkg::MASK_FLAGS;
        adc_ctl_pkg::IDX_DEBUG:      dbg_q  <= wd & adc_ctl_pkg::MASK_BIT0;
        adc_ctl_pkg::IDX_SCRATCH:    tmp_q  <= wd;
        adc_ctl_pkg::IDX_WINDOW_LOW_THRESHOLD_LO:   window_low_threshold_q[7:0]  <= wd;
        adc_ctl_pkg::IDX_WINDOW_LOW_THRESHOLD_HI:   window_low_threshold_q[15:8] <= wd;
        adc_ctl_pkg::IDX_WINDOW_HIGH_THRESHOLD_LO:   window_high_threshold_q[7:0]  <= wd;
        adc_ctl_pkg::IDX_WINDOW_HIGH_THRESHOLD_HI:   window_high_threshold_q[15:8] <= wd;
        adc_ctl_pkg::IDX_DUTY_CYCLE_TUNING:      cal_q  <= wd & adc_ctl_pkg::MASK_BIT0;
        default:                     tmp_q  <= tmp_q;
      endcase
    end
  end

  // Event pin synchroniser plus edge stage
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      evt_sync_q <= 3'h0;
    end else if (I_CLK_EN) begin
      evt_sync_q <= {evt_sync_q[1:0], I_START_EVENT};
    end
  end

  // Free-running prescaler, one-cycle enable at terminal count
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      div_q <= adc_ctl_pkg::DIV_ZERO;
      cke_q <= 1'b0;
    end else if (I_CLK_EN) begin
      div_q <= div_tick ? adc_ctl_pkg::DIV_ZERO : div_q + 8'h01;
      cke_q <= div_tick && running;
    end
  end

  // Conversion sequencer; stops when disabled, aborted or in standby with the run-in-standby bit clear
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      st_q  <= adc_ctl_pkg::ST_IDLE;
      cnt_q <= 7'h00;
      acc_q <= adc_ctl_pkg::RESET_WORD;
      res_q <= adc_ctl_pkg::RESET_WORD;
      go_q  <= 1'b0;
    end else if (I_CLK_EN) begin
      go_q <= 1'b0;
      case (st_q)
        adc_ctl_pkg::ST_IDLE: begin
          if (start) begin
            st_q  <= adc_ctl_pkg::ST_SAMPLE;
            cnt_q <= 7'h00;
            acc_q <= adc_ctl_pkg::RESET_WORD;
            go_q  <= 1'b1;
          end
        end
        adc_ctl_pkg::ST_SAMPLE: begin
          if (!running || abort) begin
            st_q <= adc_ctl_pkg::ST_IDLE;
          end else if (take) begin
            acc_q <= acc_next;
            cnt_q <= cnt_q + 7'h01;
            if (last) begin
              st_q <= adc_ctl_pkg::ST_DONE;
            end else begin
              go_q <= 1'b1;
            end
          end
        end
        adc_ctl_pkg::ST_DONE: begin
          res_q <= acc_q;
          cnt_q <= 7'h00;
          acc_q <= adc_ctl_pkg::RESET_WORD;
          if (continuous_conversion && running) begin
            st_q <= adc_ctl_pkg::ST_SAMPLE;
            go_q <= 1'b1;
          end else begin
            st_q <= adc_ctl_pkg::ST_IDLE;
          end
        end
        default: st_q <= adc_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  // Sticky flags; a new event beats a same-cycle clear
  logic [1:0] set_f;
  assign set_f = {done && hit, done};
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      flg_q <= adc_ctl_pkg::RESET_BYTE;
      irq_q <= 1'b0;
    end else if (I_CLK_EN) begin
      flg_q <= {6'h00, (flg_q[1:0] & ~(wr_flg ? wd[1:0] : 2'b00)) | set_f};
      irq_q <= |(flg_q & ien_q);
    end
  end

  // Analog control bundle registered for clean outputs
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      ana_q <= '0;
    end else if (I_CLK_EN) begin
      ana_q.converter_on      <= running;
      ana_q.sample_cap_select <= ctlc_q[adc_ctl_pkg::BIT_SAMPLE_CAP_SELECT];
      ana_q.reference_select  <= ctlc_q[adc_ctl_pkg::POS_REFERENCE_SELECT +: 2];
      ana_q.sample_go         <= go_q;
    end
  end

  assign O_WB_DAT            = rdat_q;
  assign O_WB_ACK            = ack_q;
  assign O_IRQ               = irq_q;
  assign O_CONV_CLK_EN       = cke_q;
  assign O_CONVERTER_ON      = ana_q.converter_on;
  assign O_SAMPLE_GO         = ana_q.sample_go;
  assign O_SAMPLE_CAP_SELECT = ana_q.sample_cap_select;
  assign O_REFERENCE_SELECT  = ana_q.reference_select;
  assign O_INPUT_SELECT      = mux_q[4:0];

  wire unused_ok = &{1'b0, I_WB_ADR[1:0], I_WB_SEL[3:1], I_WB_DAT[31:8],
                     ctla_q[6:3],
                     tmp_q, samp_q[7:5], cnt_q};

endmodule : adc_control_registers
`default_nettype wire

// ==== verif/adc_ctl_properties.sv ====
// Concurrent checks on the converter control block ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module adc_ctl_properties (
  input wire logic        I_REF_CLK,
  input wire logic        I_RESET,
  input wire logic        I_CLK_EN,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        O_CONVERTER_ON,
  input wire logic        O_SAMPLE_GO,
  input wire logic        O_SAMPLE_CAP_SELECT,
  input wire logic [1:0]  O_REFERENCE_SELECT,
  input wire logic        O_CONV_CLK_EN
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  // Bus answers exactly one cycle after taking, and only once
  ack_timing_a: assert property (
    I_WB_CYC && I_WB_STB && !O_WB_ACK && I_CLK_EN |=> O_WB_ACK)
    else $error("bus answer missing after request");
  ack_once_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("bus answer longer than one cycle");
  // Read data is clean outside the answer and above the byte
  dat_idle_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
    else $error("read data not zero while idle");
  dat_upper_a: assert property (
    O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // Divider and sample request give single-cycle pulses, divider never while switched off
  div_pulse_a: assert property (O_CONV_CLK_EN |=> !O_CONV_CLK_EN)
    else $error("converter clock enable wider than one cycle");
  div_idle_a: assert property (
    !O_CONVERTER_ON && !$past(O_CONVERTER_ON) |-> !O_CONV_CLK_EN)
    else $error("converter clock enable while off");
  go_pulse_a: assert property (O_SAMPLE_GO |=> !O_SAMPLE_GO)
    else $error("sample request wider than one cycle");
  // Analog selections move only as a result of a register write
  cap_stable_a: assert property (
    $changed(O_SAMPLE_CAP_SELECT) |-> O_WB_ACK || $past(O_WB_ACK))
    else $error("capacitor select changed without a write");
  ref_stable_a: assert property (
    $changed(O_REFERENCE_SELECT) |-> O_WB_ACK || $past(O_WB_ACK))
    else $error("reference select changed without a write");
endmodule : adc_ctl_properties

bind adc_control_registers adc_ctl_properties u_adc_ctl_properties (
  .I_REF_CLK, .I_RESET, .I_CLK_EN, .I_WB_CYC, .I_WB_STB, .O_WB_DAT,
  .O_WB_ACK, .O_CONVERTER_ON, .O_SAMPLE_GO, .O_SAMPLE_CAP_SELECT,
  .O_REFERENCE_SELECT, .O_CONV_CLK_EN);
`default_nettype wire

// ==== verif/adc_control_registers_bench.sv ====
// Self-checking bench for the converter control register block.
// Assumes the package is compiled first and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module adc_control_registers_bench;
  typedef struct {
    logic [4:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
  } row_t;
  logic        clk, rst, clk_en, cyc, stb, we, stby, evt, resp;
  logic        svalid = 1'b0;
  logic [6:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [9:0]  sdata;
  logic        ack, conv_on, go, cap, div_en, irq;
  logic [1:0]  refs;
  logic [4:0]  insel;
  logic [7:0]  rd;
  int          fail_count, n_checks, n, g0;
  int          go_cnt = 0;
  // Reset value, masked write and readback per register
  row_t rows [12] = '{
    '{adc_ctl_pkg::IDX_CONTROL_A, 8'hFF, 8'h87},
    '{adc_ctl_pkg::IDX_CONTROL_B, 8'hFF, 8'h07},
    '{adc_ctl_pkg::IDX_CONTROL_C, 8'hFF, 8'h77},
    '{adc_ctl_pkg::IDX_WINDOW, 8'hFF, 8'h07},
    '{adc_ctl_pkg::IDX_SAMPLEN, 8'hFF, 8'h1F},
    '{adc_ctl_pkg::IDX_POSITIVE_INPUT_SELECT, 8'hFF, 8'h1F},
    '{adc_ctl_pkg::IDX_EVENT_INPUT_CONTROL, 8'hFF, 8'h01},
    '{adc_ctl_pkg::IDX_INT_ENABLE, 8'hFF, 8'h03},
    '{adc_ctl_pkg::IDX_DEBUG, 8'hFF, 8'h01},
    '{adc_ctl_pkg::IDX_RESULT_LO, 8'hFF, 8'h00},
    '{5'h07, 8'hFF, 8'h00},
    '{5'h0E, 8'hFF, 8'h00}};

  adc_control_registers u_adc_control_registers (
    .I_REF_CLK(clk), .I_RESET(rst), .I_CLK_EN(clk_en),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_STANDBY(stby), .I_START_EVENT(evt), .I_SAMPLE_DATA(sdata),
    .I_SAMPLE_VALID(svalid), .O_CONVERTER_ON(conv_on),
    .O_SAMPLE_GO(go), .O_SAMPLE_CAP_SELECT(cap),
    .O_REFERENCE_SELECT(refs), .O_INPUT_SELECT(insel),
    .O_CONV_CLK_EN(div_en), .O_IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Analog core stand-in answers each request a cycle later while resp is high
  always @(posedge clk) begin
    svalid <= go & resp;
    if (go) go_cnt <= go_cnt + 1;
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; answer taken in the acknowledged cycle
  task automatic wb(input logic w, input logic [4:0] idx,
                    input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) fail_count++;
    rd = rdat[7:0];
    @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rdc(input logic [4:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), e, rd);
  endtask : rdc

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick

  // Steps to the next divider pulse, counting cycles
  task automatic edge_gap(output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (div_en !== 1'b1 && c < 600);
  endtask : edge_gap

  task automatic conv(input logic [2:0] code);
    logic [15:0] e;
    int k;
    k = (code == 3'h0 || code == 3'h7) ? 1 : 1 << code;
    e = 16'(k * (code[0] ? {8'h0, sdata[9:2]} : {6'h0, sdata}));
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_B, {5'h0, code});
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_A, {5'h0, code[0], 2'b01});
    wb(1'b1, adc_ctl_pkg::IDX_COMMAND, 8'h01);
    k = 0;
    do begin
      wb(1'b0, adc_ctl_pkg::IDX_INT_PEND, 8'h00);
      k++;
    end while (rd[0] !== 1'b1 && k < 2000);
    chk("ready flag", 8'h01, rd);
    rdc(adc_ctl_pkg::IDX_RESULT_LO, e[7:0]);
    rdc(adc_ctl_pkg::IDX_RESULT_HI, e[15:8]);
    rdc(adc_ctl_pkg::IDX_COMMAND, 8'h00);
    wb(1'b1, adc_ctl_pkg::IDX_INT_PEND, 8'h01);
    rdc(adc_ctl_pkg::IDX_INT_PEND, 8'h00);
  endtask : conv

  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Hang guard, well beyond the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial begin
    {rst, clk_en} = 2'b11;
    {cyc, stb, we, stby, evt, resp} = 6'h00;
    {adr, sel, wdat} = '0;
    sdata = 10'h2B7;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      rdc(rows[i].idx, 8'h00);
      wb(1'b1, rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].rd);
      wb(1'b1, rows[i].idx, 8'h00);
    end
    // Analog selections follow control C
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_C, 8'h50);
    tick(2);
    chk("cap", 8'h01, {7'h0, cap});
    chk("ref", 8'h01, {6'h0, refs});
    // Input select pin follows its register
    wb(1'b1, adc_ctl_pkg::IDX_POSITIVE_INPUT_SELECT, 8'h15);
    tick(2);
    chk("insel", 8'h15, {3'h0, insel});
    rdc(adc_ctl_pkg::IDX_RESULT_HI, 8'h00);
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_C, 8'h00);
    resp <= 1'b1;
    for (int c = 0; c < 8; c++) conv(3'(c));
    // Free running keeps requesting after one start
    g0 = go_cnt;
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_A, 8'h03);
    wb(1'b1, adc_ctl_pkg::IDX_COMMAND, 8'h01);
    repeat (40) wb(1'b0, adc_ctl_pkg::IDX_COMMAND, 8'h00);
    chk("restarts", 8'h01, {7'h0, (go_cnt - g0) >= 3});
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_A, 8'h00);
    tick(3);
    chk("conv on", 8'h00, {7'h0, conv_on});
    // Interrupt follows flag and enable, masked and cleared
    wb(1'b1, adc_ctl_pkg::IDX_INT_ENABLE, 8'h01);
    tick(2);
    chk("irq", 8'h01, {7'h0, irq});
    wb(1'b1, adc_ctl_pkg::IDX_INT_ENABLE, 8'h02);
    tick(2);
    chk("irq", 8'h00, {7'h0, irq});
    wb(1'b1, adc_ctl_pkg::IDX_INT_ENABLE, 8'h01);
    wb(1'b1, adc_ctl_pkg::IDX_INT_PEND, 8'h03);
    tick(2);
    chk("irq", 8'h00, {7'h0, irq});
    // Event starts only when enabled; core held silent
    resp <= 1'b0;
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_A, 8'h01);
    evt <= 1'b1;
    tick(8);
    rdc(adc_ctl_pkg::IDX_COMMAND, 8'h00);
    evt <= 1'b0;
    wb(1'b1, adc_ctl_pkg::IDX_EVENT_INPUT_CONTROL, 8'h01);
    evt <= 1'b1;
    tick(8);
    rdc(adc_ctl_pkg::IDX_COMMAND, 8'h01);
    // Divider period per code while a conversion waits
    for (int p = 0; p < 8; p++) begin
      wb(1'b1, adc_ctl_pkg::IDX_CONTROL_C, 8'(p));
      edge_gap(n);
      edge_gap(n);
      edge_gap(n);
      chk("period", 8'((2 << p) - 1), 8'(n - 1));
    end
    wb(1'b1, adc_ctl_pkg::IDX_COMMAND, 8'h00);
    rdc(adc_ctl_pkg::IDX_COMMAND, 8'h00);
    rdc(adc_ctl_pkg::IDX_INT_PEND, 8'h00);
    // Standby stops the converter unless told to keep running
    stby <= 1'b1;
    tick(3);
    chk("standby off", 8'h00, {7'h0, conv_on});
    wb(1'b1, adc_ctl_pkg::IDX_CONTROL_A, 8'h81);
    tick(3);
    chk("standby run", 8'h01, {7'h0, conv_on});
    finish_test();
  end
endmodule : adc_control_registers_bench
`default_nettype wire
